// ---- pkg/host_port_pkg.sv ----
// Constants and types shared by the converter host port
package host_port_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int DATA_W     = 12;           // Converted word width
  localparam int FIFO_DEPTH = 16;           // Stored words
  localparam int CNT_W      = 5;            // Fill count width
  // ----------------------------------------
  // Control register one fields and register reset values
  // ----------------------------------------
  localparam int TRIG_LO_BIT  = 2;          // threshold_sel_lo
  localparam int TRIG_HI_BIT  = 3;          // threshold_sel_hi
  localparam int PULSE_BIT    = 4;          // Pulse when set
  localparam int POLARITY_BIT = 5;          // Active high when set
  localparam int DIR_MODE_BIT = 6;          // Combined direction line
  localparam logic [DATA_W-1:0] CTRL0_RESET = 12'h000;
  localparam logic [DATA_W-1:0] CTRL1_RESET = 12'h030;
  // ----------------------------------------
  // Threshold values in words
  // ----------------------------------------
  localparam logic [CNT_W-1:0] TL1_00 = 5'h01;
  localparam logic [CNT_W-1:0] TL1_01 = 5'h04;
  localparam logic [CNT_W-1:0] TL1_10 = 5'h08;
  localparam logic [CNT_W-1:0] TL1_11 = 5'h0E;
  localparam logic [CNT_W-1:0] TL2_00 = 5'h02;
  localparam logic [CNT_W-1:0] TL2_01 = 5'h04;
  localparam logic [CNT_W-1:0] TL2_10 = 5'h08;
  localparam logic [CNT_W-1:0] TL2_11 = 5'h0C;
  // ----------------------------------------
  // Flag sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {ARMED, FIRED, DRAIN} flag_state_type;
endpackage : host_port_pkg

// ---- pkg/fifo_if.sv ----
// Push and pop signals between the port and its sample FIFO
`timescale 1ns/1ps
interface fifo_if;
  import host_port_pkg::*;
  logic              push;      // Store one word
  logic [DATA_W-1:0] wdata;     // Word to store
  logic              pop;       // Remove head word
  logic [DATA_W-1:0] rdata;     // Head word
  logic [CNT_W-1:0]  count;     // Words held
  logic              flush;     // Empty the FIFO
  modport port (output push, wdata, pop, flush, input rdata, count);
  modport store (input push, wdata, pop, flush, output rdata, count);
endinterface : fifo_if

// ---- logic/sample_fifo.sv ----
// Sixteen word sample FIFO with fill count
`timescale 1ns/1ps
module sample_fifo
  import host_port_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clocking
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic CE,
  // FIFO side
  fifo_if.store    f
);
  import host_port_pkg::*;

  localparam int AW = $clog2(DEPTH);

  logic [DATA_W-1:0] mem [DEPTH];           // Word storage
  logic [AW-1:0]     wp_r, wp_nxt;          // Write pointer
  logic [AW-1:0]     rp_r, rp_nxt;          // Read pointer
  logic [CNT_W-1:0]  cnt_r, cnt_nxt;        // Fill count
  logic              do_push, do_pop;

  assign f.rdata = mem[rp_r];               // Strict arrival order
  assign f.count = cnt_r;

  // ----------------------------------------
  // Next pointers; push when full is dropped unless a pop frees a slot
  // ----------------------------------------
  always_comb begin
    do_pop  = f.pop && (cnt_r != '0);
    do_push = f.push && (cnt_r != CNT_W'(DEPTH) || do_pop);
    wp_nxt  = do_push ? wp_r + 1'b1 : wp_r;
    rp_nxt  = do_pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r + CNT_W'(do_push) - CNT_W'(do_pop);
    if (f.flush) begin
      wp_nxt  = '0;
      rp_nxt  = '0;
      cnt_nxt = '0;
    end
  end

  // ----------------------------------------
  // Registers and storage
  // ----------------------------------------
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else if (CE) begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
      if (do_push && !f.flush) begin
        mem[wp_r] <= f.wdata;
      end
    end
  end
endmodule : sample_fifo

// ---- logic/adc_host_port_fifo_trigger.sv ----
// Host read/write port with trigger-level data-available flag
`timescale 1ns/1ps
module adc_host_port_fifo_trigger
  import host_port_pkg::*;
(
  // Clocking
  input  wire logic                     CLOCK,
  input  wire logic                     NRST,
  input  wire logic                     CE,
  // Host strobes
  input  wire logic                     CHIP_SEL_N,
  input  wire logic                     CHIP_SEL_HI,
  input  wire logic                     RD_N,
  input  wire logic                     WR_N,
  input  wire logic                     ADDR,
  // Host data bus, three signals
  input  wire logic [host_port_pkg::DATA_W-1:0] D_IN,
  output logic      [host_port_pkg::DATA_W-1:0] D_OUT,
  output logic                          D_OE,
  // Conversion side
  input  wire logic                     SAMPLE_VALID,
  input  wire logic [host_port_pkg::DATA_W-1:0] SAMPLE_DATA,
  input  wire logic                     TWO_CHANNELS,
  input  wire logic                     CONTINUOUS,
  input  wire logic                     CONVERSION_CLOCK_IN,
  input  wire logic                     OSC_CLOCK_IN,
  // Status
  output logic                          SAMPLE_READY_FLAG,
  output logic [host_port_pkg::DATA_W-1:0] CTRL0,
  output logic [host_port_pkg::DATA_W-1:0] CTRL1
);
  import host_port_pkg::*;

  fifo_if f ();

  sample_fifo #(.DEPTH(FIFO_DEPTH)) u_fifo (
    .CLOCK (CLOCK),
    .NRST  (NRST),
    .CE    (CE),
    .f     (f)
  );

  // ----------------------------------------
  // Strobe decode
  // ----------------------------------------
  logic              dir_mode;              // Combined direction line
  logic              rd_int, wr_int;        // Inner strobes
  logic              rd_r, wr_r;            // Previous strobe levels
  logic [DATA_W-1:0] ctrl0_r, ctrl0_nxt;
  logic [DATA_W-1:0] ctrl1_r, ctrl1_nxt;
  logic [DATA_W-1:0] dout_r, dout_nxt;
  logic              oe_r, oe_nxt;
  logic              rd_start, wr_start;

  assign dir_mode = ctrl1_r[DIR_MODE_BIT];

  // Inputs are synchronous; strobes are plain gates of the pins
  always_comb begin
    if (dir_mode) begin
      // Read pin ignored, host ties it high
      rd_int = !CHIP_SEL_N && CHIP_SEL_HI && WR_N;
      wr_int = !CHIP_SEL_N && CHIP_SEL_HI && !WR_N;
    end else begin
      rd_int = !CHIP_SEL_N && CHIP_SEL_HI && !RD_N && WR_N;
      wr_int = !CHIP_SEL_N && CHIP_SEL_HI && !WR_N && RD_N;
    end
    rd_start = rd_int && !rd_r;
    wr_start = wr_int && !wr_r;
  end

  // ----------------------------------------
  // Registers, data bus, FIFO control
  // ----------------------------------------
  always_comb begin
    ctrl0_nxt = ctrl0_r;
    ctrl1_nxt = ctrl1_r;
    dout_nxt  = dout_r;
    oe_nxt    = rd_int;                     // Drive for the access only
    f.pop     = rd_start;                   // One word per strobe
    f.push    = SAMPLE_VALID;
    f.wdata   = SAMPLE_DATA;
    f.flush   = 1'b0;
    if (rd_start) begin
      dout_nxt = f.rdata;
    end
    // Write lands at the trailing edge, when data is surely valid
    if (wr_r && !wr_int) begin
      if (ADDR) begin
        ctrl1_nxt = D_IN;
      end else begin
        ctrl0_nxt = D_IN;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      rd_r    <= 1'b0;
      wr_r    <= 1'b0;
      ctrl0_r <= CTRL0_RESET;
      ctrl1_r <= CTRL1_RESET;
      dout_r  <= '0;
      oe_r    <= 1'b0;
    end else if (CE) begin
      rd_r    <= rd_int;
      wr_r    <= wr_int;
      ctrl0_r <= ctrl0_nxt;
      ctrl1_r <= ctrl1_nxt;
      dout_r  <= dout_nxt;
      oe_r    <= oe_nxt;
    end
  end

  // ----------------------------------------
  // Threshold selection
  // ----------------------------------------
  logic [1:0]       trig_sel;
  logic [CNT_W-1:0] tl;                     // threshold_count

  // A differential pair is one channel, so only the count matters
  always_comb begin
    trig_sel = {ctrl1_r[TRIG_HI_BIT], ctrl1_r[TRIG_LO_BIT]};
    case (trig_sel)
      2'b00:   tl = TWO_CHANNELS ? TL2_00 : TL1_00;
      2'b01:   tl = TWO_CHANNELS ? TL2_01 : TL1_01;
      2'b10:   tl = TWO_CHANNELS ? TL2_10 : TL1_10;
      2'b11:   tl = TWO_CHANNELS ? TL2_11 : TL1_11;
      default: tl = TL1_00;
    endcase
  end

  // ----------------------------------------
  // Pulse timing clock, sampled in CLOCK domain
  // ----------------------------------------
  // Pulse width tracks half a period of the selected clock; that clock
  // is sampled like any other synchronous input, so it must be slower.
  logic tclk_r, tclk_nxt;
  logic tedge;
  always_comb begin
    tclk_nxt = CONTINUOUS ? CONVERSION_CLOCK_IN : OSC_CLOCK_IN;
    tedge    = tclk_nxt != tclk_r;          // Any half-period boundary
  end

  // ----------------------------------------
  // Flag sequencer
  // ----------------------------------------
  flag_state_type   st_r, st_nxt;
  logic [CNT_W-1:0] left_r, left_nxt;       // Reads still owed
  logic             act_r, act_nxt;         // Flag active, before polarity
  logic             pend_r, pend_nxt;       // Pulse waits for clock edge
  logic             flag_r, flag_nxt;

  always_comb begin
    st_nxt   = st_r;
    left_nxt = left_r;
    act_nxt  = act_r;
    pend_nxt = pend_r;
    case (st_r)
      ARMED: begin
        // A read in this very cycle pops a word first; judge fill next cycle
        if (f.count >= tl && !rd_start) begin
          st_nxt   = FIRED;
          left_nxt = tl;
          if (ctrl1_r[PULSE_BIT]) begin
            pend_nxt = 1'b1;
          end else begin
            act_nxt = 1'b1;
          end
        end
      end
      FIRED, DRAIN: begin
        // Pulse starts at a clock boundary, ends at the next
        if (pend_r && tedge) begin
          pend_nxt = 1'b0;
          act_nxt  = 1'b1;
        end else if (act_r && ctrl1_r[PULSE_BIT] && tedge) begin
          act_nxt = 1'b0;
        end
        if (rd_start) begin
          act_nxt  = 1'b0;                  // First read clears level
          pend_nxt = 1'b0;
          left_nxt = left_r - 1'b1;
          st_nxt   = DRAIN;
          if (left_r <= 5'h01) begin
            st_nxt = ARMED;                 // Rearm after tl reads
          end
        end
      end
      default: st_nxt = ARMED;
    endcase
    flag_nxt = ctrl1_r[POLARITY_BIT] ? act_nxt : !act_nxt;
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      st_r   <= ARMED;
      left_r <= '0;
      act_r  <= 1'b0;
      pend_r <= 1'b0;
      tclk_r <= 1'b0;
      flag_r <= 1'b0;
    end else if (CE) begin
      st_r   <= st_nxt;
      left_r <= left_nxt;
      act_r  <= act_nxt;
      pend_r <= pend_nxt;
      tclk_r <= tclk_nxt;
      flag_r <= flag_nxt;
    end
  end

  assign SAMPLE_READY_FLAG = flag_r;
  assign D_OUT = dout_r;
  assign D_OE  = oe_r;
  assign CTRL0 = ctrl0_r;
  assign CTRL1 = ctrl1_r;
endmodule : adc_host_port_fifo_trigger

// ---- tb/host_port_chk.sv ----
// Port checker for the converter host port, bound to its top module
`timescale 1ns/1ps
module host_port_chk
  import host_port_pkg::*;
(
  // Clocking
  input wire logic                              CLOCK,
  input wire logic                              NRST,
  input wire logic                              CE,
  // Host strobes
  input wire logic                              CHIP_SEL_N,
  input wire logic                              CHIP_SEL_HI,
  input wire logic                              RD_N,
  input wire logic                              WR_N,
  input wire logic                              ADDR,
  input wire logic [host_port_pkg::DATA_W-1:0]  D_IN,
  // Device outputs
  input wire logic                              D_OE,
  input wire logic                              SAMPLE_READY_FLAG,
  input wire logic [host_port_pkg::DATA_W-1:0]  CTRL0,
  input wire logic [host_port_pkg::DATA_W-1:0]  CTRL1
);
  logic       rd_act;   // Inner read strobe
  logic       wr_act;   // Inner write strobe
  logic       flag_on;  // Flag at its active level
  logic [4:0] fld;      // Control fields on the bus
  // Direction mode ignores the read pin and reuses the write pin
  assign rd_act  = !CHIP_SEL_N && CHIP_SEL_HI && WR_N && (CTRL1[DIR_MODE_BIT] || !RD_N);
  assign wr_act  = !CHIP_SEL_N && CHIP_SEL_HI && !WR_N && (CTRL1[DIR_MODE_BIT] || RD_N);
  assign flag_on = SAMPLE_READY_FLAG == CTRL1[POLARITY_BIT];
  assign fld     = D_IN[6:2];
  default clocking @(posedge CLOCK); endclocking
  // A low clock enable freezes every register, so the checks pause with it
  default disable iff (!NRST || !CE);
  a_read_drives_bus: assert property (
    rd_act |=> D_OE)
    else $error("read strobe did not enable the bus");
  a_drive_needs_read: assert property (
    D_OE |-> $past(rd_act))
    else $error("bus driven without a read");
  a_no_drive_idle: assert property (
    CHIP_SEL_N [*2] |-> !D_OE)
    else $error("bus driven while deselected");
  a_ctrl0_loads: assert property (
    $fell(wr_act) && !$past(ADDR) |=> CTRL0 == $past(D_IN))
    else $error("register zero missed a write");
  a_ctrl1_fields: assert property (
    $fell(wr_act) && $past(ADDR) |=> CTRL1[6:2] == $past(fld))
    else $error("register one fields missed a write");
  a_ctrl0_quiet: assert property (
    !$stable(CTRL0) |-> $past(wr_act, 2))
    else $error("register zero changed without a write");
  a_flag_drops_read: assert property (
    rd_act && !$past(rd_act) && !CTRL1[PULSE_BIT] |=> !flag_on)
    else $error("level flag stayed active after a read");
  a_pulse_ends: assert property (
    CTRL1[PULSE_BIT] && $rose(flag_on) |-> ##[1:10] !flag_on)
    else $error("pulse flag did not return");
endmodule : host_port_chk

bind adc_host_port_fifo_trigger host_port_chk u_chk (.CLOCK(CLOCK), .NRST(NRST), .CE(CE),
  .CHIP_SEL_N(CHIP_SEL_N), .CHIP_SEL_HI(CHIP_SEL_HI), .RD_N(RD_N), .WR_N(WR_N),
  .ADDR(ADDR), .D_IN(D_IN), .D_OE(D_OE), .SAMPLE_READY_FLAG(SAMPLE_READY_FLAG),
  .CTRL0(CTRL0), .CTRL1(CTRL1));

// ---- tb/host_bus_model.sv ----
// Processor bus model driving the host port strobes
`timescale 1ns/1ps
module host_bus_model
  import host_port_pkg::*;
(
  // Clock and mode
  input  wire logic                             clock,
  input  wire logic                             dir,
  // Bus pins
  output logic                                  chip_sel_n,
  output logic                                  chip_sel_hi,
  output logic                                  rd_n,
  output logic                                  wr_n,
  output logic                                  addr,
  output logic [host_port_pkg::DATA_W-1:0]      d_in,
  input  wire logic [host_port_pkg::DATA_W-1:0] d_out
);
  // Idle bus; read pin stays high in direction mode
  initial begin
    chip_sel_n  = 1'b1;
    chip_sel_hi = 1'b0;
    rd_n        = 1'b1;
    wr_n        = 1'b1;
    addr        = 1'b0;
    d_in        = 12'h0000;
  end
  // One access; direction or selects settle before the last qualifier
  task automatic acc(input logic w, input logic a, input logic [DATA_W-1:0] d,
                     output logic [DATA_W-1:0] q);
    @(negedge clock);
    chip_sel_hi <= 1'b1;
    addr        <= a;
    d_in        <= d;
    wr_n        <= !(dir && w);
    chip_sel_n  <= dir;
    @(negedge clock);
    if (dir) begin
      chip_sel_n <= 1'b0;
    end else if (w) begin
      wr_n <= 1'b0;
    end else begin
      rd_n <= 1'b0;
    end
    repeat (2) @(negedge clock);
    q = d_out;
    chip_sel_n <= dir;
    rd_n       <= 1'b1;
    if (!dir) begin
      wr_n <= 1'b1;
    end
    // Data and direction held a cycle past the release
    @(negedge clock);
    chip_sel_n  <= 1'b1;
    chip_sel_hi <= 1'b0;
    wr_n        <= 1'b1;
    d_in        <= ~d;
  endtask : acc
endmodule : host_bus_model

// ---- tb/adc_host_port_fifo_trigger_tb.sv ----
// Self-checking bench for the converter host port
`timescale 1ns/1ps
module adc_host_port_fifo_trigger_tb;
  import host_port_pkg::*;
  logic              clock = 0, nrst = 0, dir = 0, conversion_clock_in = 0, osc_clk = 0, ce = 1;
  logic              chip_sel_n, chip_sel_hi, rd_n, wr_n, addr, d_oe, flag;
  logic              sample_valid = 0, two_ch = 0, continuous = 0, pol, dm;
  logic [DATA_W-1:0] d_in, d_out, ctrl0, ctrl1, q, cv, c0;
  logic [DATA_W-1:0] sample_data = 12'h0000;
  logic [DATA_W-1:0] exp_q[$];   // Words in expected order
  int                bad_count = 0;
  int                n_checks  = 0;
  int                seed      = 32'h9e4c2d1a;
  always #25 clock = ~clock;
  always #200 conversion_clock_in = ~conversion_clock_in;  // Timing clocks far slower than CLOCK
  always #300 osc_clk = ~osc_clk;
  host_bus_model u_host (.clock(clock), .dir(dir), .chip_sel_n(chip_sel_n),
    .chip_sel_hi(chip_sel_hi), .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .d_in(d_in),
    .d_out(d_out));
  adc_host_port_fifo_trigger u_dut (.CLOCK(clock), .NRST(nrst), .CE(ce),
    .CHIP_SEL_N(chip_sel_n), .CHIP_SEL_HI(chip_sel_hi), .RD_N(rd_n), .WR_N(wr_n),
    .ADDR(addr), .D_IN(d_in), .D_OUT(d_out), .D_OE(d_oe), .SAMPLE_VALID(sample_valid),
    .SAMPLE_DATA(sample_data), .TWO_CHANNELS(two_ch), .CONTINUOUS(continuous),
    .CONVERSION_CLOCK_IN(conversion_clock_in), .OSC_CLOCK_IN(osc_clk), .SAMPLE_READY_FLAG(flag),
    .CTRL0(ctrl0), .CTRL1(ctrl1));
  // Threshold in words for a code and channel count
  function automatic int tl(input logic [1:0] c, input logic two);
    case (c)
      2'd0:    tl = two ? 2 : 1;
      2'd1:    tl = 4;
      2'd2:    tl = 8;
      default: tl = two ? 12 : 14;
    endcase
  endfunction : tl
  task automatic check(input string what, input logic [DATA_W-1:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic do_reset(input int n);
    @(negedge clock);
    nrst = 1'b0;
    repeat (n) @(negedge clock);
    nrst = 1'b1;
    dir  = 1'b0;
    exp_q.delete();
  endtask : do_reset
  // One-cycle pushes of random words
  task automatic push(input int n);
    repeat (n) begin
      @(negedge clock);
      sample_data  = DATA_W'($random(seed));
      sample_valid = 1'b1;
      exp_q.push_back(sample_data);
      @(negedge clock);
      sample_valid = 1'b0;
    end
  endtask : push
  // Bounded wait for the flag level, then compare
  task automatic wait_flag(input logic v, input int n);
    for (int i = 0; i < n && flag !== v; i++) @(negedge clock);
    check("flag", DATA_W'(flag), DATA_W'(v));
  endtask : wait_flag
  task automatic finish_test;
    if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  initial begin
    #1_000_000;
    bad_count++;
    finish_test();
  end
  initial begin
    do_reset(20);
    check("CTRL0", ctrl0, 12'h0000);
    check("CTRL1", ctrl1, 12'h0030);
    check("D_OE", DATA_W'(d_oe), 12'h0000);
    // Frozen clock enable: a full write access must not land
    ce = 1'b0;
    u_host.acc(1'b1, 1'b0, 12'h0a5a, q);
    check("CTRL0", ctrl0, 12'h0000);
    ce = 1'b1;
    // Every code with one and two channels, random polarity and bus mode
    for (int k = 0; k < 8; k++) begin
      do_reset(2);
      two_ch = k[2];
      pol    = 1'($random(seed));
      dm     = 1'($random(seed));
      c0     = DATA_W'($random(seed));
      cv     = {5'h00, dm, pol, 1'b0, 2'(k), 2'b00};
      u_host.acc(1'b1, 1'b1, cv, q);
      dir = dm;
      u_host.acc(1'b1, 1'b0, c0, q);
      check("CTRL1", ctrl1 & 12'h007C, cv);
      check("CTRL0", ctrl0, c0);
      push(tl(2'(k), two_ch) - 1);
      repeat (3) @(negedge clock);
      check("flag", DATA_W'(flag), DATA_W'(!pol));
      push(1);
      repeat (3) @(negedge clock);
      check("flag", DATA_W'(flag), DATA_W'(pol));
      for (int r = 0; exp_q.size() > 0; r++) begin
        u_host.acc(1'b0, 1'b0, 12'h0000, q);
        check("D_OUT", q, exp_q.pop_front());
        if (r == 0) check("flag", DATA_W'(flag), DATA_W'(!pol));
      end
    end
    // Pulse mode timed by both clocks, random polarity, threshold of one word
    for (int k = 0; k < 2; k++) begin
      do_reset(2);
      two_ch     = 1'b0;
      continuous = k[0];
      pol        = 1'($random(seed));
      u_host.acc(1'b1, 1'b1, {6'h00, pol, 1'b1, 4'h0}, q);
      push(1);
      wait_flag(pol, 40);
      wait_flag(!pol, 10);
      push(1);
      repeat (30) begin
        @(negedge clock);
        check("flag", DATA_W'(flag), DATA_W'(!pol));
      end
      u_host.acc(1'b0, 1'b0, 12'h0000, q);
      check("D_OUT", q, exp_q.pop_front());
      wait_flag(pol, 40);
    end
    finish_test();
  end
endmodule : adc_host_port_fifo_trigger_tb
